// ==== logic/slrc_top.sv ====
// serial link lock detection, lock pin, link resets and line coding
// assumes rx_word arrives unaligned on clk_sys from the serdes, clk_sys comes
// from the reference pll, and pins are synchronised inside
//
// The register offsets and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ns
`include "slrc_map.svh"
module slrc_top
	import slrc_pkg::*;
#(
	parameter int unsigned ADAPT_CYC = `SLRC_ADAPT_PERIOD_MS * `SLRC_CLK_KHZ,
	parameter int SYNC_PER = `SLRC_SYNC_PERIOD,
	parameter int MISS_MAX = `SLRC_MISS_MAX,
	parameter int CAL_CYC = `SLRC_CAL_CYC,
	parameter int VID_N = `SLRC_VID_N,
	parameter int MAX_PKT = `SLRC_MAX_PKT
)
(
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic powerdown_n_pin,
	input wire logic pll_lock_pin,
	input wire slrc_axi_req_type axi_req,
	output slrc_axi_rsp_type axi_rsp,
	input wire logic [9:0] rx_word,
	output logic [9:0] tx_sym,
	input wire logic [8:0] tx_data,
	input wire logic tx_valid,
	output logic tx_ready,
	output logic [8:0] rx_data,
	output logic rx_valid,
	input wire logic video_valid,
	output logic link_lock,
	output logic video_lock,
	output logic ctrl_en,
	output logic adapt_start,
	input wire logic lock_pin_i,
	output logic lock_pin_o,
	output logic lock_pin_oe
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	slrc_st_type s_r; // registered state
	slrc_st_type s_nxt; // next state
	logic [9:0] hit_vec; // sync seen at each bit offset
	// ----------------------------------------------------------------
	// comma search at every offset of the two-word window
	// ----------------------------------------------------------------
	for (genvar k = 0; k < 10; k++)
	begin : g_comma
		assign hit_vec[k] = (s_r.sh[k +: 10] == slrc_spc(SP_SYNC));
	end
	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb
	begin
		slrc_st_type t;
		logic [9:0] rw;
		logic [8:0] w;
		int fo;
		int d;
		int rdv;
		logic inv;
		logic take;
		logic sync_here;
		t = slrc_reset_state();
		rw = s_r.sh[s_r.ofs +: 10];
		w = tx_data ^ s_r.tx_lfsr[8:0];
		fo = 0;
		d = 2 * $countones(w) - 10;
		rdv = int'($signed(s_r.rd));
		inv = 1'b0;
		take = s_r.tx_rdy & tx_valid;
		sync_here = hit_vec[s_r.ofs];
		s_nxt = s_r;
		// pin synchronisers; the link runs on the reference-derived clock
		s_nxt.pd_s1 = powerdown_n_pin;
		s_nxt.pd_s2 = s_r.pd_s1;
		s_nxt.pll_s1 = pll_lock_pin;
		s_nxt.pll_s2 = s_r.pll_s1;
		s_nxt.pin_s1 = lock_pin_i;
		s_nxt.pin_s2 = s_r.pin_s1;
		// register bus: address and data taken in either order
		if (axi_req.awvalid && s_r.rsp.awready)
		begin
			s_nxt.aw_got = 1'b1;
			s_nxt.aw_addr = axi_req.awaddr;
		end
		if (axi_req.wvalid && s_r.rsp.wready)
		begin
			s_nxt.w_got = 1'b1;
			s_nxt.wdata = axi_req.wdata;
			s_nxt.wstrb = axi_req.wstrb;
		end
		if (s_r.rsp.bvalid && axi_req.bready)
			s_nxt.rsp.bvalid = 1'b0;
		// write performed once both halves are held
		if (s_nxt.aw_got && s_nxt.w_got && !s_nxt.rsp.bvalid)
		begin
			s_nxt.aw_got = 1'b0;
			s_nxt.w_got = 1'b0;
			s_nxt.rsp.bvalid = 1'b1;
			s_nxt.rsp.bresp = `SLRC_RESP_OKAY;
			case (s_nxt.aw_addr)
				`SLRC_OFS_CTRL:
				begin
					// only the low byte holds control bits
					if (s_nxt.wstrb[0])
					begin
						s_nxt.rst_all = s_nxt.wdata[`SLRC_CTRL_RST_ALL];
						s_nxt.oneshot = s_nxt.wdata[`SLRC_CTRL_ONESHOT];
						s_nxt.rst_link = s_nxt.wdata[`SLRC_CTRL_RST_LINK];
						s_nxt.lock_cfg = s_nxt.wdata[`SLRC_CTRL_LOCK_CFG];
						s_nxt.adapt_en = s_nxt.wdata[`SLRC_CTRL_ADAPT_EN];
					end
				end
				`SLRC_OFS_STAT:
					s_nxt.rsp.bresp = `SLRC_RESP_OKAY; // read-only, write ignored
				default:
					s_nxt.rsp.bresp = `SLRC_RESP_SLVERR; // unmapped
			endcase
		end
		// read: answered on the same edge that takes the address
		if (s_r.rsp.rvalid && axi_req.rready)
			s_nxt.rsp.rvalid = 1'b0;
		if (axi_req.arvalid && s_r.rsp.arready)
		begin
			s_nxt.rsp.rvalid = 1'b1;
			s_nxt.rsp.rdata = '0;
			s_nxt.rsp.rresp = `SLRC_RESP_OKAY;
			case (axi_req.araddr)
				`SLRC_OFS_CTRL:
				begin
					s_nxt.rsp.rdata[`SLRC_CTRL_RST_ALL] = s_r.rst_all;
					s_nxt.rsp.rdata[`SLRC_CTRL_ONESHOT] = s_r.oneshot;
					s_nxt.rsp.rdata[`SLRC_CTRL_RST_LINK] = s_r.rst_link;
					s_nxt.rsp.rdata[`SLRC_CTRL_LOCK_CFG] = s_r.lock_cfg;
					s_nxt.rsp.rdata[`SLRC_CTRL_ADAPT_EN] = s_r.adapt_en;
				end
				`SLRC_OFS_STAT:
				begin
					s_nxt.rsp.rdata[`SLRC_ST_LINK] = s_r.link_lock;
					s_nxt.rsp.rdata[`SLRC_ST_VID] = s_r.vid_lock;
					s_nxt.rsp.rdata[`SLRC_ST_PLL] = s_r.pll_s2;
					s_nxt.rsp.rdata[`SLRC_ST_ALIGN] = s_r.aligned;
					s_nxt.rsp.rdata[`SLRC_ST_OFS +: 4] = s_r.ofs;
					s_nxt.rsp.rdata[`SLRC_ST_PIN] = s_r.pin_s2;
				end
				default:
					s_nxt.rsp.rresp = `SLRC_RESP_SLVERR; // unmapped
			endcase
		end
		// ready flags for the next cycle
		s_nxt.rsp.awready = !s_nxt.aw_got && !s_nxt.rsp.bvalid;
		s_nxt.rsp.wready = !s_nxt.w_got && !s_nxt.rsp.bvalid;
		s_nxt.rsp.arready = !s_nxt.rsp.rvalid;
		// word alignment from the sync comma, video plays no part
		s_nxt.sh = {rx_word, s_r.sh[19:10]};
		for (int k = 9; k >= 0; k--)
			if (hit_vec[k])
				fo = k;
		if (!s_r.aligned)
		begin
			if (|hit_vec)
			begin
				s_nxt.aligned = 1'b1;
				s_nxt.ofs = 4'(fo);
				s_nxt.hits = 4'h1;
				s_nxt.miss = '0;
			end
		end
		else if (sync_here)
		begin
			s_nxt.miss = '0;
			if (s_r.hits != `SLRC_SYNC_LOCK_N)
				s_nxt.hits = s_r.hits + 4'h1;
		end
		else if (s_r.miss == 16'(MISS_MAX - 1))
		begin
			// syncs gone at the locked boundary: give up lock
			s_nxt.aligned = 1'b0;
			s_nxt.hits = '0;
			s_nxt.miss = '0;
		end
		else
			s_nxt.miss = s_r.miss + 16'h1;
		// descrambler, reseeded by each sync word
		s_nxt.rx_vld = 1'b0;
		if (s_r.aligned && rw == slrc_spc(SP_SYNC))
			s_nxt.rx_lfsr = `SLRC_SCR_SEED;
		else if (s_r.aligned && !slrc_is_spc(rw))
		begin
			s_nxt.rx_data = (rw[9] ? ~rw[8:0] : rw[8:0]) ^ s_r.rx_lfsr[8:0];
			s_nxt.rx_lfsr = slrc_lfsr_step(s_r.rx_lfsr);
			s_nxt.rx_vld = s_r.link_lock;
		end
		// start-up sequence: beacon, handshake, calibration, lock
		case (s_r.state)
			ST_BEACON:
				if (s_r.aligned && s_r.pll_s2 && !s_r.rst_link)
					s_nxt.state = ST_SHAKE;
			ST_SHAKE:
				if (s_r.hits == `SLRC_SYNC_LOCK_N)
				begin
					s_nxt.state = ST_CAL;
					s_nxt.tmr = '0;
				end
			ST_CAL:
				if (s_r.tmr == 32'(CAL_CYC - 1))
					s_nxt.state = ST_LOCK;
				else
					s_nxt.tmr = s_r.tmr + 32'h1;
			ST_LOCK:
				s_nxt.state = ST_LOCK;
			default:
				s_nxt.state = ST_BEACON;
		endcase
		// any loss of pll, alignment or a held reset restarts start-up
		if (!s_nxt.aligned || !s_r.pll_s2 || s_r.rst_link)
			s_nxt.state = ST_BEACON;
		s_nxt.link_lock = (s_nxt.state == ST_LOCK);
		// video lock starts only on a locked link
		if (s_nxt.link_lock && video_valid)
		begin
			if (s_r.vid_cnt != 8'(VID_N - 1))
				s_nxt.vid_cnt = s_r.vid_cnt + 8'h1;
			else
				s_nxt.vid_lock = 1'b1;
		end
		else
		begin
			s_nxt.vid_cnt = '0;
			s_nxt.vid_lock = 1'b0;
		end
		// periodic equalizer re-adapt while locked
		s_nxt.adapt_pulse = 1'b0;
		if (s_nxt.link_lock && s_r.adapt_en)
		begin
			if (s_r.adapt_tmr == ADAPT_CYC - 1)
			begin
				s_nxt.adapt_pulse = 1'b1;
				s_nxt.adapt_tmr = '0;
			end
			else
				s_nxt.adapt_tmr = s_r.adapt_tmr + 32'h1;
		end
		else
			s_nxt.adapt_tmr = '0;
		// transmit symbol choice
		if (s_r.state != ST_BEACON)
			s_nxt.scnt = (s_r.scnt == 16'(SYNC_PER - 1)) ? 16'h0 : s_r.scnt + 16'h1;
		else
			s_nxt.scnt = '0;
		s_nxt.pkt = take ? s_r.pkt + 8'h1 : 8'h0;
		if (s_r.rst_link)
			s_nxt.tx_sym = slrc_spc(SP_IDLE); // no connection attempts
		else if (s_r.state == ST_BEACON)
		begin
			s_nxt.tx_sym = slrc_spc(SP_SYNC); // beacon
			s_nxt.tx_lfsr = `SLRC_SCR_SEED;
		end
		else if (take)
		begin
			// balance: invert when the word pushes disparity further out
			inv = (rdv > 0 && d > 0) || (rdv < 0 && d < 0);
			s_nxt.tx_sym = inv ? {1'b1, ~w} : {1'b0, w};
			s_nxt.rd = 6'(inv ? rdv - d : rdv + d);
			s_nxt.tx_lfsr = slrc_lfsr_step(s_r.tx_lfsr);
		end
		else if (s_r.scnt == 16'(SYNC_PER - 1))
		begin
			s_nxt.tx_sym = slrc_spc(SP_SYNC);
			s_nxt.tx_lfsr = `SLRC_SCR_SEED;
		end
		else
			s_nxt.tx_sym = slrc_spc(SP_IDLE);
		// no data on a sync slot or after a full packet
		s_nxt.tx_rdy = s_nxt.link_lock && !s_nxt.rst_link
			&& (s_nxt.scnt != 16'(SYNC_PER - 1))
			&& (s_nxt.pkt != 8'(MAX_PKT));
		// pulse link reset: link restarts, registers kept
		if (s_r.oneshot)
		begin
			t.rst_link = s_nxt.rst_link;
			t.lock_cfg = s_nxt.lock_cfg;
			t.adapt_en = s_nxt.adapt_en;
			t.oneshot = 1'b0;
			t.pd_s1 = s_nxt.pd_s1;
			t.pd_s2 = s_nxt.pd_s2;
			t.pll_s1 = s_nxt.pll_s1;
			t.pll_s2 = s_nxt.pll_s2;
			t.pin_s1 = s_nxt.pin_s1;
			t.pin_s2 = s_nxt.pin_s2;
			t.aw_got = s_nxt.aw_got;
			t.aw_addr = s_nxt.aw_addr;
			t.w_got = s_nxt.w_got;
			t.wdata = s_nxt.wdata;
			t.wstrb = s_nxt.wstrb;
			t.rsp = s_nxt.rsp;
			s_nxt = t;
		end
		// full reset: trigger bit or powerdown pin low; bus answer survives
		if (s_r.rst_all || !s_r.pd_s2)
		begin
			t = slrc_reset_state();
			t.pd_s1 = s_nxt.pd_s1;
			t.pd_s2 = s_nxt.pd_s2;
			t.pll_s1 = s_nxt.pll_s1;
			t.pll_s2 = s_nxt.pll_s2;
			t.pin_s1 = s_nxt.pin_s1;
			t.pin_s2 = s_nxt.pin_s2;
			t.aw_got = s_nxt.aw_got;
			t.aw_addr = s_nxt.aw_addr;
			t.w_got = s_nxt.w_got;
			t.wdata = s_nxt.wdata;
			t.wstrb = s_nxt.wstrb;
			t.rsp = s_nxt.rsp;
			s_nxt = t;
		end
		// indicators derived from the final next state
		s_nxt.ctrl_en = s_nxt.link_lock && !s_nxt.rst_link;
		s_nxt.lock_oe = !(s_nxt.link_lock && (!s_nxt.lock_cfg || s_nxt.vid_lock));
	end
	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys)
	begin
		if (srst)
			s_r <= slrc_reset_state();
		else
			s_r <= s_nxt;
	end
	// ----------------------------------------------------------------
	// outputs, all from the state register
	// ----------------------------------------------------------------
	assign axi_rsp = s_r.rsp;
	assign tx_sym = s_r.tx_sym;
	assign tx_ready = s_r.tx_rdy;
	assign rx_data = s_r.rx_data;
	assign rx_valid = s_r.rx_vld;
	assign link_lock = s_r.link_lock;
	assign video_lock = s_r.vid_lock;
	assign ctrl_en = s_r.ctrl_en;
	assign adapt_start = s_r.adapt_pulse;
	assign lock_pin_o = s_r.rst_all; // always low outside the trigger cycle
	assign lock_pin_oe = s_r.lock_oe;
	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (srst);
	sequence sq_oneshot;
		$rose(s_r.oneshot);
	endsequence
	sequence sq_link_cleared;
		!s_r.oneshot && !s_r.link_lock && s_r.state == ST_BEACON && !s_r.aligned;
	endsequence
	AST_LOCK_NEEDS_PLL: assert property (!lock_pin_oe |-> s_r.aligned && $past(s_r.pll_s2))
		else $error("lock pin released without pll lock or alignment");
	AST_ONESHOT: assert property (sq_oneshot |=> sq_link_cleared ##1 !s_r.link_lock)
		else $error("pulse link reset did not restart the link");
	AST_ONESHOT_KEEP: assert property (sq_oneshot |=> $stable(s_r.lock_cfg))
		else $error("pulse link reset disturbed a register");
	AST_RESET_ALL: assert property ($rose(s_r.rst_all) |=> !s_r.rst_all && !s_r.lock_cfg
		&& s_r.adapt_en && s_r.state == ST_BEACON)
		else $error("full reset trigger did not reset the block");
	AST_HELD_RESET: assert property (s_r.rst_link |=> s_r.state == ST_BEACON
		&& tx_sym == slrc_spc(SP_IDLE))
		else $error("held link reset still attempts connection");
	AST_CTRL_EN: assert property (ctrl_en == (link_lock && !s_r.rst_link))
		else $error("control enable not in step with lock");
	AST_MISS_DROP: assert property (s_r.aligned && !hit_vec[s_r.ofs]
		&& s_r.miss == 16'(MISS_MAX - 1) |=> !link_lock && !s_r.aligned)
		else $error("lock kept after sync words vanished");
	AST_VIDEO_AFTER_LINK: assert property (video_lock |-> link_lock)
		else $error("video lock without link lock");
	AST_LOCK_SRC: assert property (s_r.lock_cfg && !video_lock |-> lock_pin_oe)
		else $error("lock pin released without video lock");
	AST_ADAPT: assert property (adapt_start |-> link_lock && $past(s_r.adapt_en))
		else $error("re-adapt started on an unlocked link");
	AST_SYNC_SLOT: assert property (s_r.state != ST_BEACON && !s_r.rst_link && !s_r.oneshot
		&& !s_r.rst_all && s_r.pd_s2 && s_r.scnt == 16'(SYNC_PER - 1)
		|=> tx_sym == slrc_spc(SP_SYNC))
		else $error("periodic sync word missing");
	AST_PKT_CAP: assert property (s_r.pkt <= 8'(MAX_PKT))
		else $error("packet longer than the cap");
endmodule

// ==== logic/slrc_map.svh ====
// constants of the serial link lock and reset control block
// assumes a 100 MHz system clock and an 8-bit AXI4-Lite byte address space
`ifndef SLRC_MAP_SVH
`define SLRC_MAP_SVH
// ----------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------
`define SLRC_CLK_KHZ 100000
`define SLRC_ADAPT_PERIOD_MS 1000
`define SLRC_SYNC_PERIOD 64
`define SLRC_SYNC_LOCK_N 4'h4
`define SLRC_MISS_MAX 256
`define SLRC_CAL_CYC 1024
`define SLRC_VID_N 16
`define SLRC_MAX_PKT 32
// ----------------------------------------------------------------
// register offsets and fields
// ----------------------------------------------------------------
`define SLRC_OFS_CTRL 8'h00
`define SLRC_OFS_STAT 8'h04
`define SLRC_CTRL_RST_ALL 0
`define SLRC_CTRL_ONESHOT 1
`define SLRC_CTRL_RST_LINK 2
`define SLRC_CTRL_LOCK_CFG 3
`define SLRC_CTRL_ADAPT_EN 4
`define SLRC_CTRL_ADAPT_RST 1'b1
`define SLRC_ST_LINK 0
`define SLRC_ST_VID 1
`define SLRC_ST_PLL 2
`define SLRC_ST_ALIGN 3
`define SLRC_ST_OFS 4
`define SLRC_ST_PIN 8
`define SLRC_RESP_OKAY 2'h0
`define SLRC_RESP_SLVERR 2'h2
// ----------------------------------------------------------------
// line code
// ----------------------------------------------------------------
`define SLRC_SPC_MASK 10'h2B2
`define SLRC_SCR_SEED 16'hACE1
`endif

// ==== logic/slrc_pkg.sv ====
// types of the serial link lock and reset control block
// assumes slrc_map.svh is on the include path
package slrc_pkg;
`include "slrc_map.svh"
	// link start-up states, gray coded along the usual path
	typedef enum logic [2:0] {
		ST_BEACON = 3'h0,
		ST_SHAKE = 3'h1,
		ST_CAL = 3'h3,
		ST_LOCK = 3'h2
	} slrc_state_type;
	// the eight special symbols
	typedef enum logic [2:0] {
		SP_SYNC = 3'h0,
		SP_IDLE = 3'h1,
		SP_SOP = 3'h2,
		SP_EOP = 3'h3,
		SP_CTL0 = 3'h4,
		SP_CTL1 = 3'h5,
		SP_CTL2 = 3'h6,
		SP_CTL3 = 3'h7
	} slrc_special_type;
	// register bus request from the master
	typedef struct packed {
		logic awvalid;
		logic [7:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [7:0] araddr;
		logic rready;
	} slrc_axi_req_type;
	// register bus answer to the master
	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} slrc_axi_rsp_type;
	// whole state of the block
	typedef struct packed {
		logic pd_s1;
		logic pd_s2;
		logic pll_s1;
		logic pll_s2;
		logic pin_s1;
		logic pin_s2;
		logic rst_all;
		logic oneshot;
		logic rst_link;
		logic lock_cfg;
		logic adapt_en;
		slrc_state_type state;
		logic aligned;
		logic [3:0] ofs;
		logic [3:0] hits;
		logic [15:0] miss;
		logic [31:0] tmr;
		logic [31:0] adapt_tmr;
		logic link_lock;
		logic vid_lock;
		logic [7:0] vid_cnt;
		logic [19:0] sh;
		logic [15:0] rx_lfsr;
		logic [8:0] rx_data;
		logic rx_vld;
		logic [15:0] tx_lfsr;
		logic [5:0] rd;
		logic [9:0] tx_sym;
		logic [15:0] scnt;
		logic [7:0] pkt;
		logic tx_rdy;
		logic adapt_pulse;
		logic ctrl_en;
		logic lock_oe;
		logic aw_got;
		logic [7:0] aw_addr;
		logic w_got;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		slrc_axi_rsp_type rsp;
	} slrc_st_type;
	// special symbol: index tripled, then masked; any two differ in at least three bits
	function automatic logic [9:0] slrc_spc(input slrc_special_type idx);
		return {idx, idx, idx, 1'b0} ^ `SLRC_SPC_MASK;
	endfunction
	// true for any of the eight special symbols
	function automatic logic slrc_is_spc(input logic [9:0] sym);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < 8; i++)
			if (sym == slrc_spc(slrc_special_type'(3'(i))))
				hit = 1'b1;
		return hit;
	endfunction
	// one step of the scrambler sequence
	function automatic logic [15:0] slrc_lfsr_step(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	// state after reset
	function automatic slrc_st_type slrc_reset_state();
		slrc_st_type r;
		r = '0;
		r.adapt_en = `SLRC_CTRL_ADAPT_RST;
		r.state = ST_BEACON;
		r.rx_lfsr = `SLRC_SCR_SEED;
		r.tx_lfsr = `SLRC_SCR_SEED;
		r.tx_sym = slrc_spc(SP_IDLE);
		r.lock_oe = 1'b1;
		r.rsp.awready = 1'b1;
		r.rsp.wready = 1'b1;
		r.rsp.arready = 1'b1;
		return r;
	endfunction
endpackage

// ==== bench/slrc_remote_model.sv ====
// remote link end: sync, one data word, then idle; noise when unplugged
// assumes the block's clock, a raw 10-bit lane and slrc_map.svh on the include path
`timescale 1ns/1ns
`include "slrc_map.svh"
module slrc_remote_model
#(
	parameter int SYNC_PER = 8,
	parameter logic [8:0] DATA = 9'h1A5
)
(
	input wire logic clk_sys,
	input wire logic cable_ok,
	output logic [9:0] rx_word,
	output logic lock_oe
);
	// ----
	// symbol source
	// ----
	logic [7:0] cnt_r = 8'h00; // slot counter within one sync period
	logic [9:0] word_r = 10'h000; // symbol on the lane
	localparam logic [15:0] SEED = `SLRC_SCR_SEED; // scrambler state right after a sync
	// unplugged lane toggles so no stale symbol lingers
	always_ff @(posedge clk_sys)
	begin
		cnt_r <= (cnt_r >= 8'(SYNC_PER - 1)) ? 8'h00 : cnt_r + 8'h01;
		if (!cable_ok)
			word_r <= (word_r == 10'h3FF) ? 10'h000 : 10'h3FF;
		else if (cnt_r == 8'h00)
			word_r <= 10'h2B2; // sync with comma, also beacon
		else if (cnt_r == 8'h01)
			word_r <= {1'b1, ~(DATA ^ SEED[8:0])}; // inverted scrambled data word
		else
			word_r <= 10'h220; // idle special fills spare slots
	end
	assign rx_word = word_r;
	// remote pulls the shared lock wire low while it has no link
	// remote has no held link reset: nothing ever sets one across the link
	assign lock_oe = !cable_ok;
endmodule

// ==== bench/testbench.sv ====
// top bench: drives registers, pins and lane, judges lock and reset behaviour
// assumes the remote model on the lane and a pull-up on the shared lock wire
`timescale 1ns/1ns
module testbench;
	import slrc_pkg::*;
	// ----
	// settings and signals
	// ----
	localparam int ADAPT = 200; // shortened adapt period
	localparam int SPER = 8; // sync period
	localparam int MISS = 32; // missed-sync limit
	localparam int VIDN = 16; // video lock count
	localparam int MPKT = 5; // packet length cap, short so the sync slot does not hide it
	localparam logic [8:0] RXD = 9'h1A5; // word the remote sends after each sync
	localparam logic [9:0] SYNC = 10'h2B2; // sync special
	localparam logic [9:0] IDLE = 10'h220; // idle special
	logic clk_sys = 1'b0;
	logic srst = 1'b1;
	logic pd_n = 1'b1;
	logic pll = 1'b0;
	logic cable_ok = 1'b0;
	logic video_valid = 1'b0;
	logic tx_valid = 1'b0;
	logic [8:0] tx_data = 9'h000;
	slrc_axi_req_type req = '0;
	slrc_axi_rsp_type rsp;
	logic [9:0] rx_word, tx_sym;
	logic [8:0] rx_data;
	logic rx_valid, tx_ready, link_lock, video_lock, ctrl_en, adapt_start;
	logic lock_pin_o, lock_pin_oe, rem_oe, lock_wire;
	int err_count = 0;
	int n_checks = 0;
	// open-drain lock wire with pull-up, both ends may pull it
	assign lock_wire = (lock_pin_oe ? lock_pin_o : 1'b1) && !rem_oe;
	always #5 clk_sys = ~clk_sys;
	slrc_top #(.ADAPT_CYC(ADAPT), .SYNC_PER(SPER), .MISS_MAX(MISS), .CAL_CYC(8),
		.VID_N(VIDN), .MAX_PKT(MPKT)) slrc_top_inst (.clk_sys(clk_sys), .srst(srst),
		.powerdown_n_pin(pd_n), .pll_lock_pin(pll), .axi_req(req), .axi_rsp(rsp),
		.rx_word(rx_word), .tx_sym(tx_sym), .tx_data(tx_data), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
		.video_valid(video_valid), .link_lock(link_lock), .video_lock(video_lock),
		.ctrl_en(ctrl_en), .adapt_start(adapt_start), .lock_pin_i(lock_wire),
		.lock_pin_o(lock_pin_o), .lock_pin_oe(lock_pin_oe));
	slrc_remote_model #(.SYNC_PER(SPER), .DATA(RXD)) slrc_remote_model_inst (.clk_sys(clk_sys),
		.cable_ok(cable_ok), .rx_word(rx_word), .lock_oe(rem_oe));
	// ----
	// shared tasks
	// ----
	// compare and count
	task automatic chk(input logic [33:0] got, input logic [33:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("unexpected value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// register write, address and data offered together
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		req.awvalid <= 1'b1;
		req.awaddr <= a;
		req.wvalid <= 1'b1;
		req.wdata <= d;
		req.wstrb <= 4'hF;
		req.bready <= 1'b1;
		do
		begin
			@(posedge clk_sys);
			if (rsp.awready)
				req.awvalid <= 1'b0;
			if (rsp.wready)
				req.wvalid <= 1'b0;
		end
		while (!rsp.bvalid);
		req.bready <= 1'b0;
	endtask
	// register read, returns response code above data
	task automatic rd(input logic [7:0] a, output logic [33:0] v);
		@(posedge clk_sys);
		req.arvalid <= 1'b1;
		req.araddr <= a;
		req.rready <= 1'b1;
		do
		begin
			@(posedge clk_sys);
			if (rsp.arready)
				req.arvalid <= 1'b0;
		end
		while (!rsp.rvalid);
		v = {rsp.rresp, rsp.rdata};
		req.rready <= 1'b0;
	endtask
	// bounded wait for a lock level, polling instead of a fixed delay
	task automatic wlock(input logic v, input int n);
		for (int i = 0; i < n && link_lock !== v; i++)
			@(posedge clk_sys);
	endtask
	// ----
	// scenarios
	// ----
	// reset values, unmapped read, no lock without pll, no video lock early
	task automatic t_reset();
		logic [33:0] v;
		int n;
		@(posedge clk_sys);
		chk({rsp.awready, rsp.wready, rsp.arready, rsp.bvalid, rsp.rvalid}, 5'b11100);
		chk({tx_sym, lock_pin_oe, lock_pin_o, link_lock}, {IDLE, 3'b100});
		rd(8'h00, v);
		chk(v, 34'h10);
		rd(8'h08, v);
		chk(v[33:32], 2'h2);
		cable_ok <= 1'b1;
		video_valid <= 1'b1;
		n = 0;
		repeat (100)
		begin
			@(posedge clk_sys);
			n += rx_valid;
		end
		chk(n, 0);
		chk({link_lock, video_lock, ctrl_en}, 3'b000);
		video_valid <= 1'b0;
	endtask
	// start-up to lock without video; periodic sync out
	task automatic t_lock();
		logic [33:0] v;
		pll <= 1'b1;
		wlock(1'b1, 400);
		chk({link_lock, ctrl_en, lock_pin_oe}, 3'b110);
		for (int i = 0; i < SPER + 2 && tx_sym !== SYNC; i++)
			@(posedge clk_sys);
		chk(tx_sym, SYNC);
		rd(8'h04, v);
		chk({v[8], v[0]}, 2'b11);
		for (int i = 0; i < 2 * SPER && !rx_valid; i++)
			@(posedge clk_sys);
		chk({rx_valid, rx_data}, {1'b1, RXD});
	endtask
	// adapt period, then disabled
	task automatic t_adapt();
		int n;
		for (n = 0; n < ADAPT + 20 && !adapt_start; n++)
			@(posedge clk_sys);
		n = 0;
		do
		begin
			@(posedge clk_sys);
			n++;
		end
		while (!adapt_start && n < 1000);
		chk(n, ADAPT);
		wr(8'h00, 32'h0);
		n = 0;
		repeat (ADAPT + 20)
		begin
			@(posedge clk_sys);
			n += adapt_start;
		end
		chk(n, 0);
		wr(8'h00, 32'h10);
	endtask
	// lock pin waits for video lock when so selected
	task automatic t_video();
		wr(8'h00, 32'h18);
		repeat (VIDN + 4) @(posedge clk_sys);
		chk({video_lock, lock_pin_oe}, 2'b01);
		video_valid <= 1'b1;
		for (int i = 0; i < VIDN + 8 && !video_lock; i++)
			@(posedge clk_sys);
		repeat (2) @(posedge clk_sys);
		chk({video_lock, lock_pin_oe}, 2'b10);
		video_valid <= 1'b0;
		wr(8'h00, 32'h10);
	endtask
	// unplug, drop after missed syncs, relock on reconnect
	task automatic t_loss();
		cable_ok <= 1'b0;
		repeat (MISS / 2) @(posedge clk_sys);
		chk(link_lock, 1'b1);
		wlock(1'b0, MISS + 8);
		chk({link_lock, ctrl_en, lock_pin_oe}, 3'b001);
		cable_ok <= 1'b1;
		wlock(1'b1, 400); // wait for self-recovery, no reset
		chk(link_lock, 1'b1);
	endtask
	// held reset, oneshot and full reset
	task automatic t_resets();
		logic [33:0] v;
		wr(8'h00, 32'h14);
		repeat (20) @(posedge clk_sys);
		chk({link_lock, ctrl_en, tx_sym}, {2'b00, IDLE});
		rd(8'h00, v);
		chk(v, 34'h14);
		wr(8'h00, 32'h10);
		wlock(1'b1, 400);
		chk(link_lock, 1'b1);
		wr(8'h00, 32'h08);
		wr(8'h00, 32'h0A); // link reset after a setting change
		repeat (2) @(posedge clk_sys);
		chk(link_lock, 1'b0);
		rd(8'h00, v);
		chk(v, 34'h08);
		wlock(1'b1, 400);
		chk(link_lock, 1'b1);
		wr(8'h00, 32'h09);
		rd(8'h00, v);
		chk(v, 34'h10);
		wlock(1'b1, 400);
		wr(8'h00, 32'h08);
		pd_n <= 1'b0;
		repeat (6) @(posedge clk_sys);
		chk(link_lock, 1'b0);
		pd_n <= 1'b1;
		repeat (6) @(posedge clk_sys);
		rd(8'h00, v);
		chk(v, 34'h10);
		wr(8'h00, 32'h10); // reprogram after the power cycle
		wlock(1'b1, 400);
		chk(link_lock, 1'b1);
	endtask
	// packet cap under steady offer, idle fill after
	task automatic t_tx();
		int run, top, takes;
		run = 0;
		top = 0;
		takes = 0;
		tx_valid <= 1'b1;
		tx_data <= 9'h0A5;
		repeat (100)
		begin
			@(posedge clk_sys);
			run = tx_ready ? run + 1 : 0;
			takes += tx_ready;
			if (run > top)
				top = run;
		end
		tx_valid <= 1'b0;
		chk({top <= MPKT, takes > 0}, 2'b11);
		chk(top, MPKT);
		repeat (3) @(posedge clk_sys);
		top = 0;
		repeat (30)
		begin
			@(posedge clk_sys);
			top += (tx_sym !== IDLE && tx_sym !== SYNC);
		end
		chk(top, 0);
	endtask
	// ----
	// run control
	// ----
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// watchdog far beyond the expected few thousand cycles
	initial
	begin
		#200000;
		err_count++;
		$display("unexpected hang at %0t", $time);
		finish_test();
	end
	// main sequence
	initial
	begin
		repeat (6) @(posedge clk_sys);
		srst <= 1'b0;
		t_reset();
		t_lock();
		t_adapt();
		t_video();
		t_loss();
		t_resets();
		t_tx();
		finish_test();
	end
endmodule
